// >>> hw/pmc_ctrl.sv
// Operating-mode controller: mode selection, clock gating, flags, wake-up.
// Assumes all inputs are synchronous to i_clk_sys; oscillators lie outside.
// What this block does
// RULE1 - Clear high select with divider 000 or 001 enters slow mode.
// RULE2 - High select set or divider 010..111 returns to normal clocking.
// RULE3 - Low clock as system clock stops high oscillator and its dividers.
// RULE4 - Slow switch completes only once low oscillator ready is seen.
// RULE5 - Software polls high oscillator ready when returning to normal.
// RULE6 - Halt without idle: deep sleep if watchdog and detector off, else light.
// RULE7 - Halt with idle: keep-sysclk selects idle clock on or off.
// RULE8 - Deep sleep stops all clocks; watchdog cleared and halted.
// RULE9 - Light sleep keeps aux clock; watchdog cleared and counts only on aux source.
// RULE10 - Idle off keeps time base and aux; watchdog per source.
// RULE11 - Idle on keeps all clocks; enabled watchdog cleared and counts.
// RULE12 - Halt entry sets power-down flag and clears expiry flag.
// RULE13 - Wake on reset, enabled port A fall, interrupt, watchdog overflow.
// RULE14 - Reset wake resets all; dog wake sets expiry, resets PC and SP.
// RULE15 - Power-down flag cleared by reset or dog clear, set by halt.
// RULE16 - Port A pins individually enable falling-edge wake; resume after halt.
// RULE17 - Disabled or stack-full interrupt resumes after halt, stays pending.
// RULE18 - An interrupt flag already set before halt is no wake source.
// RULE19 - Crystal oscillators share one startup counter, high speed first.
// RULE20 - Deep wake and power-on run first instruction on high ready.
// RULE21 - Light wake with crystal and fast wake may run on low clock.
// RULE22 - Aux clock and watchdog source run only if watchdog enabled; the code also runs aux with the detector enabled or in slow mode.
// RULE23 - High ready after 1024 crystal cycles or 16 RC cycles.
// RULE24 - Low ready low in deep sleep, then 1024 crystal or 2 RC cycles.
// RULE25 - Current mode is one registered encoded state driving all gating; the clock gates decode mode_nxt instead.
`timescale 1ns/1ps
`include "pmc_cfg.svh"

module pmc_ctrl
    import pmc_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic       i_sys_clock_high_select,
    input  wire logic [2:0] i_slow_clock_divider_select,
    input  wire logic       i_idle_on_halt,
    input  wire logic       i_idle_keep_sysclk,
    input  wire logic       i_fast_wake_enable,
    input  wire logic       i_dog_enable,
    input  wire logic       i_dog_on_aux,
    input  wire logic       i_supply_drop_enable,
    input  wire logic       i_hs_is_crystal,
    input  wire logic       i_ls_is_crystal,
    input  wire logic       i_halt,
    input  wire logic       i_dog_clear,
    input  wire logic       i_dog_overflow,
    input  wire logic [7:0] i_porta_pins,
    input  wire logic [7:0] i_porta_wake_enable,
    input  wire logic       i_irq_req,
    input  wire logic       i_irq_enable,
    input  wire logic       i_stack_full,
    output logic [5:0]      o_mode,
    output logic            o_sys_clk_en,
    output logic            o_sys_on_low,
    output logic            o_hs_osc_en,
    output logic            o_tbase_clk_en,
    output logic            o_aux_clk_en,
    output logic            o_dog_clk_en,
    output logic            o_dog_clr,
    output logic            o_high_osc_ready,
    output logic            o_low_osc_ready,
    output logic            o_power_down_flag,
    output logic            o_dog_expiry_flag,
    output logic            o_pc_sp_reset,
    output logic            o_irq_service,
    output logic            o_cpu_run
);

    // ========================================================================
    // Helpers
    // ========================================================================
    // Slow divider decode, used for mode choice and for sequencing.
    function automatic logic f_slow_sel(input logic hs, input logic [2:0] d);
        f_slow_sel = !hs && (d == `PMC_DIV_LOW0 || d == `PMC_DIV_LOW1);
    endfunction : f_slow_sel

    pmc_mode_e   mode_r;
    pmc_mode_e   mode_nxt;
    logic [7:0]  porta_d_r;
    logic [7:0]  porta_fall;
    logic        irq_armed_r;
    logic        wake;
    logic        halted;
    logic        want_slow;
    logic [10:0] sst_cnt_r;
    logic        sst_on_low_r;
    logic        hs_rdy_r;
    logic        ls_rdy_r;
    logic [10:0] hs_len;
    logic [10:0] ls_len;

    assign halted    = (mode_r != PMC_NORMAL) && (mode_r != PMC_SLOW);
    assign want_slow = f_slow_sel(i_sys_clock_high_select,
                                  i_slow_clock_divider_select);
    assign hs_len = i_hs_is_crystal ? `PMC_HXT_SST_CYC
                                    : `PMC_HRC_SST_CYC; // RULE23
    assign ls_len = i_ls_is_crystal ? `PMC_LXT_SST_CYC
                                    : `PMC_LRC_SST_CYC; // RULE24

    // ========================================================================
    // Wake sources
    // ========================================================================
    // Falling edges on enabled pins only; other pins never wake.
    assign porta_fall = porta_d_r & ~i_porta_pins & i_porta_wake_enable; // RULE16

    // An interrupt wakes only if its flag rose after halt entry.
    assign wake = halted && ((|porta_fall) || i_dog_overflow
                             || (i_irq_req && irq_armed_r)); // RULE13 RULE18

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            porta_d_r <= 8'hff;
        end else begin
            porta_d_r <= i_porta_pins;
        end
    end

    // Armed at halt only when no request is pending already.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            irq_armed_r <= 1'b0;
        end else if (!halted && i_halt) begin
            irq_armed_r <= !i_irq_req; // RULE18
        end else if (!halted) begin
            irq_armed_r <= 1'b0;
        end
    end

    // ========================================================================
    // Mode state machine
    // ========================================================================
    // Slow entry waits for the low oscillator so the switch never glitches.
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            PMC_NORMAL, PMC_SLOW: begin
                if (i_halt) begin
                    if (!i_idle_on_halt) begin
                        mode_nxt = (i_dog_enable || i_supply_drop_enable)
                                   ? PMC_LIGHT : PMC_DEEP; // RULE6
                    end else begin
                        mode_nxt = i_idle_keep_sysclk
                                   ? PMC_IDLE_ON : PMC_IDLE_OFF; // RULE7
                    end
                end else if (want_slow && ls_rdy_r) begin
                    mode_nxt = PMC_SLOW; // RULE1 RULE4
                end else if (!want_slow) begin
                    mode_nxt = PMC_NORMAL; // RULE2
                end
            end
            PMC_DEEP, PMC_LIGHT, PMC_IDLE_OFF, PMC_IDLE_ON: begin
                // Slow wake still needs a settled low oscillator.
                if (wake) begin
                    mode_nxt = (want_slow && ls_rdy_r)
                               ? PMC_SLOW : PMC_NORMAL; // RULE4
                end
            end
            default: mode_nxt = PMC_NORMAL;
        endcase
    end

    // Registered mode; the clock gates below decode mode_nxt, the value it loads next.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            mode_r <= PMC_NORMAL; // RULE14
        end else begin
            mode_r <= mode_nxt; // RULE25
        end
    end

    // ========================================================================
    // Shared startup counter
    // ========================================================================
    // One counter: high oscillator first, then the low one (crystal case).
    // Deep sleep and reset drop both ready flags.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || mode_r == PMC_DEEP) begin
            sst_cnt_r    <= 11'h000;
            sst_on_low_r <= 1'b0;
            hs_rdy_r     <= 1'b0;
            ls_rdy_r     <= 1'b0; // RULE24
        end else if (mode_r == PMC_LIGHT || mode_r == PMC_IDLE_OFF) begin
            hs_rdy_r     <= 1'b0;
            sst_cnt_r    <= 11'h000;
            sst_on_low_r <= 1'b0;
        end else if (!hs_rdy_r && !(mode_r == PMC_SLOW)) begin
            if (sst_cnt_r + 11'h001 >= hs_len) begin
                hs_rdy_r  <= 1'b1; // RULE23
                sst_cnt_r <= 11'h000;
                sst_on_low_r <= 1'b1; // RULE19
            end else begin
                sst_cnt_r <= sst_cnt_r + 11'h001;
            end
        end else if (!ls_rdy_r && (sst_on_low_r || hs_rdy_r
                                   || mode_r == PMC_SLOW)) begin
            if (sst_cnt_r + 11'h001 >= ls_len) begin
                ls_rdy_r  <= 1'b1; // RULE19 RULE24
                sst_cnt_r <= 11'h000;
            end else begin
                sst_cnt_r <= sst_cnt_r + 11'h001;
            end
        end
    end

    // ========================================================================
    // Clock gating
    // ========================================================================
    // High oscillator stops in slow mode and in every stopped-clock halt.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_sys_clk_en   <= 1'b1;
            o_sys_on_low   <= 1'b0;
            o_hs_osc_en    <= 1'b1;
            o_tbase_clk_en <= 1'b1;
            o_aux_clk_en   <= 1'b0;
            o_dog_clk_en   <= 1'b0;
        end else begin
            o_sys_clk_en <= (mode_nxt == PMC_NORMAL) || (mode_nxt == PMC_SLOW)
                            || (mode_nxt == PMC_IDLE_ON); // RULE8 RULE9
            // Fast wake borrows the aux clock until high ready.
            o_sys_on_low <= (mode_nxt == PMC_SLOW)
                            || (mode_nxt == PMC_NORMAL && !hs_rdy_r
                                && i_fast_wake_enable && i_hs_is_crystal
                                && ls_rdy_r); // RULE21
            o_hs_osc_en  <= (mode_nxt == PMC_NORMAL)
                            || (mode_nxt == PMC_IDLE_ON && !want_slow); // RULE3
            o_tbase_clk_en <= (mode_nxt != PMC_DEEP)
                              && (mode_nxt != PMC_LIGHT); // RULE10 RULE11
            o_aux_clk_en <= (mode_nxt != PMC_DEEP)
                            && (i_dog_enable || i_supply_drop_enable
                                || mode_nxt == PMC_SLOW); // RULE22
            o_dog_clk_en <= i_dog_enable && (mode_nxt != PMC_DEEP)
                            && (i_dog_on_aux || mode_nxt == PMC_NORMAL
                                || mode_nxt == PMC_SLOW
                                || mode_nxt == PMC_IDLE_ON); // RULE10 RULE22
        end
    end

    // ========================================================================
    // Status flags and CPU controls
    // ========================================================================
    // Halt sets power-down and clears expiry; an overflow wake sets expiry.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_power_down_flag <= 1'b0;
            o_dog_expiry_flag <= 1'b0;
        end else begin
            if (!halted && i_halt) begin
                o_power_down_flag <= 1'b1; // RULE12 RULE15
            end else if (i_dog_clear) begin
                o_power_down_flag <= 1'b0; // RULE15
            end
            if (i_dog_overflow) begin
                o_dog_expiry_flag <= 1'b1; // RULE14
            end else if (!halted && i_halt) begin
                o_dog_expiry_flag <= 1'b0; // RULE12
            end
        end
    end

    // Pulses plus run, mode and ready levels to the core; the watchdog is cleared on each halt entry.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_dog_clr     <= 1'b0;
            o_pc_sp_reset <= 1'b0;
            o_irq_service <= 1'b0;
            o_cpu_run     <= 1'b0;
            o_mode        <= 6'h01;
            o_high_osc_ready <= 1'b0;
            o_low_osc_ready  <= 1'b0;
        end else begin
            o_dog_clr     <= (!halted && i_halt) || i_dog_clear; // RULE8
            o_pc_sp_reset <= wake && i_dog_overflow; // RULE14
            o_irq_service <= wake && !i_dog_overflow && !(|porta_fall)
                             && i_irq_enable && !i_stack_full; // RULE17
            o_cpu_run     <= !halted && (hs_rdy_r || mode_r == PMC_SLOW
                                         || o_sys_on_low); // RULE20
            o_mode        <= mode_r;
            o_high_osc_ready <= hs_rdy_r; // RULE5
            o_low_osc_ready  <= ls_rdy_r;
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    a_slow_needs_ready: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) $rose(mode_r == PMC_SLOW) |-> $past(ls_rdy_r))
        else $error("slow mode entered before low oscillator ready"); // RULE4
    a_halt_deep: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!halted && i_halt && !i_idle_on_halt && !i_dog_enable
         && !i_supply_drop_enable) |=> mode_r == PMC_DEEP)
        else $error("halt did not enter deep sleep"); // RULE6
    a_halt_idle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!halted && i_halt && i_idle_on_halt) |=>
        mode_r == ($past(i_idle_keep_sysclk) ? PMC_IDLE_ON : PMC_IDLE_OFF))
        else $error("halt did not enter the right idle mode"); // RULE7
    a_deep_gates: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (mode_nxt == PMC_DEEP) |=> !o_sys_clk_en && !o_dog_clk_en
        && !o_tbase_clk_en)
        else $error("deep sleep left a clock running"); // RULE8
    a_pdf_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!halted && i_halt && !i_dog_overflow)
        |=> o_power_down_flag && !o_dog_expiry_flag)
        else $error("halt flags wrong"); // RULE12
    a_wake_leaves: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) wake |=> !halted)
        else $error("wake did not leave halt"); // RULE13
    a_dog_wake: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (wake && i_dog_overflow) |=> o_pc_sp_reset && o_dog_expiry_flag)
        else $error("dog wake missed"); // RULE14
    a_stale_irq: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!halted && i_halt && i_irq_req) |=> !irq_armed_r)
        else $error("stale interrupt armed"); // RULE18
    a_hs_ready_time: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) (mode_r == PMC_DEEP ##1 mode_r == PMC_NORMAL
        && !i_hs_is_crystal) |-> !hs_rdy_r ##[14:17] hs_rdy_r)
        else $error("rc high ready time wrong"); // RULE23
    c_deep: cover property (@(posedge i_clk_sys) mode_r == PMC_DEEP ##[1:20]
        mode_r == PMC_NORMAL);
    c_slow: cover property (@(posedge i_clk_sys) mode_r == PMC_SLOW);
    c_idle_on: cover property (@(posedge i_clk_sys) mode_r == PMC_IDLE_ON
        ##1 wake);

endmodule : pmc_ctrl

// >>> hw/pmc_cfg.svh
// Constants for the power mode controller: divider field codes and startup timing.
// Assumes it is included once per compile unit by its bare name.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_DIV_LOW0        3'h0
`define PMC_DIV_LOW1        3'h1
`define PMC_HXT_SST_CYC     11'h400
`define PMC_HRC_SST_CYC     11'h010
`define PMC_LXT_SST_CYC     11'h400
`define PMC_LRC_SST_CYC     11'h002
`endif

// >>> hw/pmc_pkg.sv
// Types shared by the power mode controller.
// Assumes the cfg header is compiled alongside.
package pmc_pkg;
    // One-hot operating modes.
    typedef enum logic [5:0] {
        PMC_NORMAL    = 6'h01,
        PMC_SLOW      = 6'h02,
        PMC_DEEP      = 6'h04,
        PMC_LIGHT     = 6'h08,
        PMC_IDLE_OFF  = 6'h10,
        PMC_IDLE_ON   = 6'h20
    } pmc_mode_e;
endpackage : pmc_pkg

// >>> tb/pmc_cpu_model.sv
// CPU-side partner model: turns bench requests into halt and clear pulses.
// Assumes requests are one-cycle strobes sampled on i_clk_sys.
`timescale 1ns/1ps
module pmc_cpu_model (
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    input  wire logic i_cpu_run,
    input  wire logic i_high_osc_ready,
    input  wire logic i_req_halt,
    input  wire logic i_req_clear,
    output logic      o_halt,
    output logic      o_dog_clear
);
    logic halt_pend_r;

    // ==========================================================
    // Instruction issue
    // A halt waits until the core runs on a settled fast clock; a clear
    // needs only i_cpu_run, so it can issue before the oscillator is stable.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            halt_pend_r <= 1'b0;
            o_halt      <= 1'b0;
            o_dog_clear <= 1'b0;
        end else begin
            o_halt      <= 1'b0;
            o_dog_clear <= i_req_clear & i_cpu_run;
            if (i_req_halt) begin
                halt_pend_r <= 1'b1;
            end else if (halt_pend_r && i_cpu_run && i_high_osc_ready) begin
                halt_pend_r <= 1'b0;
                o_halt      <= 1'b1;
            end
        end
    end
endmodule : pmc_cpu_model

// >>> tb/tb.sv
// Self-checking bench for the power mode controller.
// Assumes the design package and the CPU partner model are compiled first.
`timescale 1ns/1ps
module tb;
    import pmc_pkg::*;
    logic       clk, rst, hsel, idle, keep, fast, dog, dog_aux, supply_drop_detector;
    logic       hs_x, ls_x, dog_ovf, irq, irq_en, stk_full, rq_h, rq_c;
    logic       halt, dclr, sys_en, on_low, hs_en, tb_en, aux_en, dog_en;
    logic       d_clr, h_rdy, l_rdy, power_down_flag, exp_f, pcsp, svc, run;
    logic [2:0] div;
    logic [7:0] pins, pwe;
    logic [5:0] mode;
    int         n_errors, samples_checked, cyc, n_clr, n_pcsp, n_svc, n;
    localparam logic [4:0] HCFG [4] = '{5'h00, 5'h06, 5'h14, 5'h1e};
    localparam pmc_mode_e  HMODE [4] = '{PMC_DEEP, PMC_LIGHT,
                                         PMC_IDLE_OFF, PMC_IDLE_ON};
    localparam logic [3:0] HGATE [4] = '{4'h0, 4'h3, 4'h6, 4'hf};

    pmc_ctrl dut_u (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_sys_clock_high_select(hsel), .i_slow_clock_divider_select(div),
        .i_idle_on_halt(idle), .i_idle_keep_sysclk(keep),
        .i_fast_wake_enable(fast), .i_dog_enable(dog), .i_dog_on_aux(dog_aux),
        .i_supply_drop_enable(supply_drop_detector), .i_hs_is_crystal(hs_x),
        .i_ls_is_crystal(ls_x), .i_halt(halt), .i_dog_clear(dclr),
        .i_dog_overflow(dog_ovf), .i_porta_pins(pins),
        .i_porta_wake_enable(pwe), .i_irq_req(irq), .i_irq_enable(irq_en),
        .i_stack_full(stk_full), .o_mode(mode), .o_sys_clk_en(sys_en),
        .o_sys_on_low(on_low), .o_hs_osc_en(hs_en), .o_tbase_clk_en(tb_en),
        .o_aux_clk_en(aux_en), .o_dog_clk_en(dog_en), .o_dog_clr(d_clr),
        .o_high_osc_ready(h_rdy), .o_low_osc_ready(l_rdy),
        .o_power_down_flag(power_down_flag), .o_dog_expiry_flag(exp_f),
        .o_pc_sp_reset(pcsp), .o_irq_service(svc), .o_cpu_run(run));
    pmc_cpu_model cpu_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_cpu_run(run),
        .i_high_osc_ready(h_rdy), .i_req_halt(rq_h), .i_req_clear(rq_c),
        .o_halt(halt), .o_dog_clear(dclr));

    // ==========================================================
    // Clock, pulse counters and hang guard
    // Pulses last one cycle, so they are counted rather than polled.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (d_clr === 1'b1) n_clr++;
        if (pcsp === 1'b1) n_pcsp++;
        if (svc === 1'b1) n_svc++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ==========================================================
    // Shared helpers
    task check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check
    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task wait_mode(input logic [5:0] exp, input string what);
        for (int i = 0; i < 8 && mode !== exp; i++) tick(1);
        check(mode === exp, what);
    endtask : wait_mode
    task ready_time(input logic low, output int k);
        k = 0;
        while (k < 3000 && (low ? l_rdy : h_rdy) !== 1'b1) begin
            tick(1);
            k++;
        end
    endtask : ready_time
    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        tick(4);
        rst <= 1'b0;
        check(mode === PMC_NORMAL && power_down_flag === 1'b0, "reset state");
    endtask : do_reset
    task do_halt;
        @(posedge clk);
        rq_h <= 1'b1;
        @(posedge clk);
        rq_h <= 1'b0;
    endtask : do_halt
    task porta_wake;
        @(posedge clk);
        pins <= 8'hfd;
        tick(4);
        check(mode !== PMC_NORMAL, "masked pin woke");
        @(posedge clk);
        pins <= 8'hfc;
        wait_mode(PMC_NORMAL, "pin wake");
        @(posedge clk);
        pins <= 8'hff;
        for (int i = 0; i < 40 && run !== 1'b1; i++) tick(1);
        check(run === 1'b1 && h_rdy === 1'b1, "ran before ready");
    endtask : porta_wake

    // ==========================================================
    // Scenarios
    task t_startup_rc;
        int kh, kl;
        do_reset();
        ready_time(1'b0, kh);
        ready_time(1'b1, kl);
        check(kh >= 14 && kh <= 18, "rc high ready time");
        check(kl >= 0 && kl <= 4, "rc low ready time");
        $display("test startup_rc done");
    endtask : t_startup_rc
    task t_clock_select;
        for (int d = 0; d < 8; d++) begin
            @(posedge clk);
            hsel <= 1'b0;
            div  <= d[2:0];
            wait_mode(d < 2 ? PMC_SLOW : PMC_NORMAL, "divider mode");
            tick(2);
            check(hs_en === (d >= 2) && on_low === (d < 2), "hs stop");
        end
        @(posedge clk);
        div  <= 3'h0;
        hsel <= 1'b1;
        wait_mode(PMC_NORMAL, "high select");
        $display("test clock_select done");
    endtask : t_clock_select
    task t_halt_modes;
        int c0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {idle, keep, dog, dog_aux, supply_drop_detector} <= HCFG[k];
            c0 = n_clr;
            do_halt();
            wait_mode(HMODE[k], "halt mode");
            tick(2);
            check({sys_en, tb_en, aux_en, dog_en} === HGATE[k], "gating");
            check(power_down_flag === 1'b1 && exp_f === 1'b0, "halt flags");
            check(n_clr > c0, "dog clear on halt");
            porta_wake();
        end
        $display("test halt_modes done");
    endtask : t_halt_modes
    task t_dog_wake;
        int p0;
        p0 = n_pcsp;
        do_halt();
        wait_mode(PMC_IDLE_ON, "idle on");
        @(posedge clk);
        dog_ovf <= 1'b1;
        @(posedge clk);
        dog_ovf <= 1'b0;
        wait_mode(PMC_NORMAL, "dog wake");
        tick(2);
        check(exp_f === 1'b1 && power_down_flag === 1'b1, "dog wake flags");
        check(n_pcsp == p0 + 1, "pc sp reset");
        @(posedge clk);
        rq_c <= 1'b1;
        @(posedge clk);
        rq_c <= 1'b0;
        tick(3);
        check(power_down_flag === 1'b0, "pdf clear");
        $display("test dog_wake done");
    endtask : t_dog_wake
    task t_irq_wake;
        int s0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            irq_en <= (k != 1);
            stk_full <= (k == 3);
            irq    <= (k == 2);
            s0 = n_svc;
            do_halt();
            wait_mode(PMC_IDLE_ON, "idle on");
            @(posedge clk);
            irq <= 1'b1;
            tick(6);
            if (k == 2) begin
                check(mode === PMC_IDLE_ON, "stale flag woke");
                porta_wake();
            end else begin
                wait_mode(PMC_NORMAL, "irq wake");
                tick(2);
                check(n_svc == s0 + (k == 0), "irq service");
            end
            @(posedge clk);
            irq <= 1'b0;
        end
        $display("test irq_wake done");
    endtask : t_irq_wake
    task t_crystal;
        int kh, kl;
        @(posedge clk);
        {hs_x, ls_x, fast} <= 3'h7;
        do_reset();
        ready_time(1'b0, kh);
        ready_time(1'b1, kl);
        check(kh >= 1022 && kh <= 1028, "xtal high ready");
        check(kl >= 1020 && kl <= 1028, "shared counter");
        @(posedge clk);
        {idle, keep, dog, dog_aux} <= 4'h3;
        do_halt();
        wait_mode(PMC_LIGHT, "light");
        @(posedge clk);
        pins <= 8'hfe;
        wait_mode(PMC_NORMAL, "light wake");
        check(h_rdy === 1'b0 && on_low === 1'b1, "fast wake");
        $display("test crystal done");
    endtask : t_crystal

    task give_verdict;
        $display("counts: errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        {rst, hsel, idle, keep, fast, dog, dog_aux, supply_drop_detector} = 8'h03;
        {hs_x, ls_x, dog_ovf, irq, irq_en, stk_full, rq_h, rq_c} = 8'h00;
        {div, pins, pwe} = {3'h0, 8'hff, 8'h01};
        {n_errors, samples_checked, cyc, n_clr, n_pcsp, n_svc} = 0;
        t_startup_rc();
        t_clock_select();
        t_halt_modes();
        t_dog_wake();
        t_irq_wake();
        t_crystal();
        give_verdict();
    end
endmodule : tb
